// >>> rtl/ach_pkg.sv
package ach_pkg;

    // conversion timing, printed figures in ns
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned T_FULL_SLOW_NS  = 17000;
    localparam int unsigned T_FULL_FAST_NS  = 10000;
    localparam int unsigned T_SHORT_SLOW_NS = 15000;
    localparam int unsigned T_SHORT_FAST_NS = 8000;

    // longest times round down
    localparam int unsigned CYC_FULL_SLOW   = T_FULL_SLOW_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_FULL_FAST   = T_FULL_FAST_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_SHORT_SLOW  = T_SHORT_SLOW_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_SHORT_FAST  = T_SHORT_FAST_NS / CLK_PERIOD_NS;
    // comparator sees a new trial code one cycle late
    localparam int unsigned TRIAL_MIN_CYC   = 2;

    localparam int unsigned RES_FULL        = 16;
    localparam int unsigned RES_SHORT       = 14;
    localparam logic [15:0] RESULT_RST      = 16'h0000;

    typedef enum logic [2:0] {
        ACH_IDLE  = 3'b001,
        ACH_RESET = 3'b010,
        ACH_TRIAL = 3'b100
    } ach_state_t;

    // conversion setup sampled at the trigger's falling edge
    typedef struct packed {
        logic fast;
        logic short_cycle;
    } ach_cfg_t;

endpackage : ach_pkg

// >>> rtl/ach_sar_dac.sv
`timescale 1ns/1ps
// successive-approximation register: one bit trial per step
module ach_sar_dac #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic             cmp_hi,
    output logic [WIDTH-1:0]      code_q,
    output logic [WIDTH-1:0]      mask_q
);

    always_ff @(posedge mclk) begin
        if (sys_rst || clear) begin
            // cleared DAC starts on the top-bit trial
            code_q <= {1'b1, {(WIDTH-1){1'b0}}};
            mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step && mask_q != '0) begin
            // keep or drop the trial bit, then try the next one
            code_q <= (cmp_hi ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
            mask_q <= mask_q >> 1;
        end
    end

endmodule : ach_sar_dac

// >>> rtl/ach_conv_ctrl.sv
`timescale 1ns/1ps
module ach_conv_ctrl #(
    parameter int unsigned CYC_FULL_SLOW  = ach_pkg::CYC_FULL_SLOW,
    parameter int unsigned CYC_FULL_FAST  = ach_pkg::CYC_FULL_FAST,
    parameter int unsigned CYC_SHORT_SLOW = ach_pkg::CYC_SHORT_SLOW,
    parameter int unsigned CYC_SHORT_FAST = ach_pkg::CYC_SHORT_FAST
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic          conv_start,
    input  wire ach_pkg::ach_cfg_t cfg,
    input  wire logic          cmp_hi,
    output logic               status_q,
    output logic               dac_clear_q,
    output logic [15:0]        dac_code_q,
    output logic [15:0]        result_q,
    output logic               done_q
);

    localparam int unsigned CW = 15;

    ach_pkg::ach_state_t state_q;
    ach_pkg::ach_cfg_t   cfg_q;
    logic                start_d1_q;
    logic [CW-1:0]       cnt_q;
    logic [CW-1:0]       total_q;
    logic [4:0]          bits_left_q;
    logic [CW-1:0]       step_len_q;
    logic [CW-1:0]       step_cnt_q;
    logic                step;
    logic                fall;
    logic                take;
    logic                last;
    logic [15:0]         sar_code;

    // conversion time in cycles for the chosen variant and length
    function automatic logic [CW-1:0] conv_cycles(input ach_pkg::ach_cfg_t c);
        logic [31:0] n;
        n = 32'(CYC_FULL_SLOW);
        case ({c.fast, c.short_cycle})
            2'b00:   n = 32'(CYC_FULL_SLOW);
            2'b01:   n = 32'(CYC_SHORT_SLOW);
            2'b10:   n = 32'(CYC_FULL_FAST);
            2'b11:   n = 32'(CYC_SHORT_FAST);
            default: n = 32'(CYC_FULL_SLOW);
        endcase
        return n[CW-1:0];
    endfunction : conv_cycles

    // trial pace: even spread, never faster than the comparator path
    // conversion times under two cycles a trial leave low bits unresolved
    function automatic logic [CW-1:0] trial_len(input ach_pkg::ach_cfg_t c);
        logic [CW-1:0] len;
        len = conv_cycles(c) / (c.short_cycle ? 15'(ach_pkg::RES_SHORT + 1)
                                              : 15'(ach_pkg::RES_FULL + 1));
        if (len < 15'(ach_pkg::TRIAL_MIN_CYC)) begin
            len = 15'(ach_pkg::TRIAL_MIN_CYC);
        end
        return len;
    endfunction : trial_len

    // trigger edge detect
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_d1_q <= 1'b0;
        end else begin
            start_d1_q <= conv_start;
        end
    end

    assign fall = start_d1_q && !conv_start;
    // falls while busy are ignored
    assign take = (state_q == ach_pkg::ACH_IDLE) && fall;
    assign last = (cnt_q == total_q - 15'(1));
    assign step = (state_q == ach_pkg::ACH_TRIAL) && (step_cnt_q == step_len_q - 15'(1));

    // sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= ach_pkg::ACH_IDLE;
        end else begin
            case (state_q)
                ach_pkg::ACH_IDLE: begin
                    if (fall) begin
                        state_q <= ach_pkg::ACH_RESET;
                    end
                end
                ach_pkg::ACH_RESET: begin
                    state_q <= ach_pkg::ACH_TRIAL;
                end
                ach_pkg::ACH_TRIAL: begin
                    if (last) begin
                        state_q <= ach_pkg::ACH_IDLE;
                    end
                end
                default: begin
                    state_q <= ach_pkg::ACH_IDLE;
                end
            endcase
        end
    end

    // setup and conversion length, taken at the trigger fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q   <= '0;
            total_q <= '0;
        end else if (take) begin
            cfg_q   <= cfg;
            total_q <= conv_cycles(cfg);
        end
    end

    // trial pacing, fixed for the whole conversion
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            step_len_q <= 15'(ach_pkg::TRIAL_MIN_CYC);
        end else if (take) begin
            step_len_q <= trial_len(cfg);
        end
    end

    // trials still to run
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bits_left_q <= '0;
        end else if (take) begin
            bits_left_q <= cfg.short_cycle ? 5'(ach_pkg::RES_SHORT)
                                           : 5'(ach_pkg::RES_FULL);
        end else if (step && bits_left_q != '0) begin
            bits_left_q <= bits_left_q - 5'(1);
        end
    end

    // elapsed conversion time
    always_ff @(posedge mclk) begin
        if (sys_rst || state_q == ach_pkg::ACH_IDLE) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 15'(1);
        end
    end

    // cycles since the last trial step
    always_ff @(posedge mclk) begin
        if (sys_rst || state_q == ach_pkg::ACH_IDLE) begin
            step_cnt_q <= '0;
        end else begin
            step_cnt_q <= step ? '0 : step_cnt_q + 15'(1);
        end
    end

    // busy status
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_q <= 1'b0;
        end else if (state_q == ach_pkg::ACH_IDLE && fall) begin
            status_q <= 1'b1;
        end else if (state_q == ach_pkg::ACH_TRIAL && last) begin
            status_q <= 1'b0;
        end
    end

    // DAC clear pulse, before any trial
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dac_clear_q <= 1'b0;
        end else begin
            dac_clear_q <= (state_q == ach_pkg::ACH_IDLE) && fall;
        end
    end

    ach_sar_dac #(
        .WIDTH (16)
    ) u_sar (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clear   ((state_q == ach_pkg::ACH_IDLE) && fall),
        .step    (step && bits_left_q != '0),
        .cmp_hi  (cmp_hi),
        .code_q  (sar_code),
        .mask_q  ()
    );

    // code on the DAC, one cycle behind the approximation register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dac_code_q <= ach_pkg::RESULT_RST;
        end else begin
            dac_code_q <= sar_code;
        end
    end

    // completion pulse, one cycle with the status fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ach_pkg::ACH_TRIAL) && last;
        end
    end

    // result latch at the status fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_q <= ach_pkg::RESULT_RST;
        end else if (state_q == ach_pkg::ACH_TRIAL && last) begin
            // short cycle leaves the two low bits cleared
            result_q <= cfg_q.short_cycle ? (sar_code & 16'hfffc) : sar_code;
        end
    end

endmodule : ach_conv_ctrl

// >>> tb/ach_conv_checker.sv
`timescale 1ns/1ps
module ach_conv_checker #(
    parameter int unsigned CYC_FULL_SLOW  = ach_pkg::CYC_FULL_SLOW,
    parameter int unsigned CYC_FULL_FAST  = ach_pkg::CYC_FULL_FAST,
    parameter int unsigned CYC_SHORT_SLOW = ach_pkg::CYC_SHORT_SLOW,
    parameter int unsigned CYC_SHORT_FAST = ach_pkg::CYC_SHORT_FAST
) (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              conv_start,
    input wire ach_pkg::ach_cfg_t cfg,
    input wire logic              cmp_hi,
    input wire logic              status_q,
    input wire logic              dac_clear_q,
    input wire logic [15:0]       dac_code_q,
    input wire logic [15:0]       result_q,
    input wire logic              done_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ach_pkg::ach_cfg_t cfg_q;
    logic [11:0]       cnt_q;
    logic [11:0]       exp_c;
    // busy length expected for the setup latched at the start
    assign exp_c = 12'(cfg_q.short_cycle ? (cfg_q.fast ? CYC_SHORT_FAST : CYC_SHORT_SLOW)
                      : (cfg_q.fast ? CYC_FULL_FAST : CYC_FULL_SLOW));
    always_ff @(posedge mclk) begin
        if (sys_rst) cfg_q <= '0;
        else if (!status_q) cfg_q <= cfg;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst || !status_q) cnt_q <= '0;
        else cnt_q <= cnt_q + 12'h001;
    end
    property p_start;
        $fell(conv_start) && !status_q && !$past(sys_rst) |=> status_q && dac_clear_q;
    endproperty
    a_start: assert property (p_start) else $error("no busy after trigger fall");
    property p_clr;
        dac_clear_q == $rose(status_q);
    endproperty
    a_clr: assert property (p_clr) else $error("dac clear not at start");
    property p_clr_pulse;
        dac_clear_q |=> !dac_clear_q;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("dac clear too long");
    property p_dac_clr;
        dac_clear_q |=> dac_code_q == 16'h8000;
    endproperty
    a_dac_clr: assert property (p_dac_clr) else $error("dac not cleared before trials");
    property p_len_full;
        $fell(status_q) && !cfg_q.short_cycle |-> cnt_q == exp_c;
    endproperty
    a_len_full: assert property (p_len_full) else $error("full busy length wrong");
    property p_len_short;
        $fell(status_q) && cfg_q.short_cycle |-> cnt_q == exp_c;
    endproperty
    a_len_short: assert property (p_len_short) else $error("short busy length wrong");
    property p_done;
        done_q == $fell(status_q);
    endproperty
    a_done: assert property (p_done) else $error("done not at busy fall");
    property p_result;
        $changed(result_q) |-> done_q;
    endproperty
    a_result: assert property (p_result) else $error("result moved outside done");
    property p_short_lsb;
        done_q && cfg_q.short_cycle |-> result_q[1:0] == 2'h0;
    endproperty
    a_short_lsb: assert property (p_short_lsb) else $error("short result low bits set");
endmodule : ach_conv_checker

bind ach_conv_ctrl ach_conv_checker #(.CYC_FULL_SLOW(CYC_FULL_SLOW),
    .CYC_FULL_FAST(CYC_FULL_FAST), .CYC_SHORT_SLOW(CYC_SHORT_SLOW),
    .CYC_SHORT_FAST(CYC_SHORT_FAST)) ach_conv_checker_i (.mclk(mclk), .sys_rst(sys_rst),
    .conv_start(conv_start), .cfg(cfg), .cmp_hi(cmp_hi), .status_q(status_q),
    .dac_clear_q(dac_clear_q), .dac_code_q(dac_code_q), .result_q(result_q), .done_q(done_q));

// >>> tb/ach_host_model.sv
`timescale 1ns/1ps
// sample-hold with flip-flop or inverted-status control, and comparator
module ach_host_model (
    input wire logic        mclk,
    input wire logic        basic,
    input wire logic        conv_start,
    input wire logic        status_q,
    input wire logic [15:0] dac_code_q,
    input wire logic [15:0] ain,
    output logic            cmp_hi
);
    logic        start_q = 1'b0;
    logic        stat_q  = 1'b0;
    logic        hold_q  = 1'b0;
    logic [15:0] held_q  = 16'h0000;
    logic        hold;
    // basic scheme holds while status is high
    assign hold = basic ? status_q : hold_q;
    always_ff @(posedge mclk) begin
        start_q <= conv_start;
        stat_q  <= status_q;
        if (conv_start && !start_q) hold_q <= 1'b1;
        else if (stat_q && !status_q) hold_q <= 1'b0;
        if (!hold) held_q <= ain;
    end
    assign cmp_hi = dac_code_q <= held_q;
endmodule : ach_host_model

// >>> tb/test_adc_conversion_handshake.sv
`timescale 1ns/1ps
module test_adc_conversion_handshake;
    logic mclk = 1'b0, sys_rst = 1'b1, conv_start = 1'b0, cmp_hi, status_q, dac_clear_q, done_q;
    ach_pkg::ach_cfg_t cfg = '0;
    logic [15:0] ain = 16'h0000, dac_code_q, result_q;
    logic basic = 1'b0;
    int n_errors = 0, n_checks = 0;
    logic [15:0] vals [8] = '{16'h0000, 16'hffff, 16'h8001, 16'h5a5f,
                              16'h7ffe, 16'h0003, 16'hc3a5, 16'h1234};
    logic [15:0] ncyc [4] = '{16'h0030, 16'h002a, 16'h0024, 16'h0020};
    initial forever #5 mclk = ~mclk;
    ach_conv_ctrl #(.CYC_FULL_SLOW(48), .CYC_FULL_FAST(36), .CYC_SHORT_SLOW(42),
        .CYC_SHORT_FAST(32)) ach_conv_ctrl_i (.mclk(mclk), .sys_rst(sys_rst),
        .conv_start(conv_start), .cfg(cfg), .cmp_hi(cmp_hi), .status_q(status_q),
        .dac_clear_q(dac_clear_q), .dac_code_q(dac_code_q), .result_q(result_q),
        .done_q(done_q));
    ach_host_model ach_host_model_i (.mclk(mclk), .basic(basic), .conv_start(conv_start),
        .status_q(status_q), .dac_code_q(dac_code_q), .ain(ain), .cmp_hi(cmp_hi));
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one conversion, input moved after hold, stray trigger while busy
    task automatic conv(input logic [1:0] c, input logic [15:0] a, input logic [15:0] n);
        logic [15:0] k;
        k = 16'h0000;
        cfg = ach_pkg::ach_cfg_t'(c);
        ain = a;
        // acquisition time before the hold
        repeat (2) @(negedge mclk);
        conv_start = 1'b1;
        @(negedge mclk) conv_start = 1'b0;
        @(negedge mclk) ain = ~a;
        chk(16'(dac_clear_q), 16'h0001);
        while (status_q === 1'b1 && k < 16'h0400) begin
            conv_start = (k == 16'h0005);
            @(negedge mclk) k++;
        end
        if (k == 16'h0400) begin
            n_errors++;
            end_sim;
        end else begin
            chk(k, n);
            chk(16'(done_q), 16'h0001);
            chk(result_q, c[0] ? a & 16'hfffc : a);
        end
    endtask : conv
    initial begin
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            basic = i[2];
            conv(i[1:0], vals[i], ncyc[i % 4]);
        end
        end_sim;
    end
endmodule : test_adc_conversion_handshake
